// [hdl/mbad_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mbad_regs.svh"

// Functional notes
// - Six top address bits equal page setting
// - Page setting picks one of 64 pages
// - Banks placed independently, same page allowed
// - Per-bank decoder from mid bits and size
// - Offset settings fix block start and end
// - Chip selects only inside page and block
// - Latch address from active bus, strobe local
// - Delay access start until decoding completes
// - Reads drive addressed data onto active bus
// - Writes pass bus data to addressed location
// - Acknowledge after selectable delay on active bus
// - One mode setting picks exactly one bus
// - Narrow mode routes address bits 0-15
// - Wide mode routes address bits 1-16
// - Nonvolatile ready states routed to interrupt level
// - Device type chosen per half bank
// - Command delay 40, 60 or 80 ns
// - Wide mode: address bit 0 gates low device, byte enable gates high device
module mbad_top (
    input  wire logic                           clk_sys_in,
    input  wire logic                           rst_in,
    input  wire logic                           mode_sys_bus_in,
    input  wire logic                           wide_mode_in,
    input  wire logic [1:0]                     cmd_delay_sel_in,
    input  wire logic [2:0]                     ack_delay_sel_in,
    input  wire mbad_pkg::mbad_bank_cfg_t [1:0] bank_cfg_in,
    input  wire mbad_pkg::mbad_dev_t [3:0]      dev_type_in,
    input  wire mbad_pkg::mbad_bus_in_t         sys_bus_in,
    input  wire mbad_pkg::mbad_bus_in_t         loc_bus_in,
    input  wire logic                           loc_astb_n_in,
    input  wire logic [15:0]                    mem_rdata_in,
    input  wire logic [1:0]                     ee_ready_in,
    input  wire logic [1:0]                     ee_route_en_in,
    input  wire logic [2:0]                     rdy_level_in,
    input  wire logic [2:0]                     nrdy_level_in,
    output logic [15:0]                         sys_data_out,
    output logic                                sys_data_oe_out,
    output logic                                sys_ack_n_out,
    output logic [15:0]                         loc_data_out,
    output logic                                loc_data_oe_out,
    output logic                                loc_ack_n_out,
    output logic [15:0]                         mem_addr_out,
    output logic [15:0]                         mem_cs_n_out,
    output logic                                mem_oe_n_out,
    output logic                                mem_we_n_out,
    output logic [15:0]                         mem_wdata_out,
    output logic [1:0]                          page_hit_out,
    output logic [7:0]                          int_req_out
);
    import mbad_pkg::*;

    // Reset image of the whole state; strobes and enables idle inactive
    localparam mbad_state_t ST_RST = '{
        sync1:     `MBAD_SYNC_RST,
        sync2:     `MBAD_SYNC_RST,
        sync3:     `MBAD_SYNC_RST,
        filt:      `MBAD_SYNC_RST,
        fsm:       S_IDLE,
        mem_cs_n:  16'hFFFF,
        mem_oe_n:  1'b1,
        mem_we_n:  1'b1,
        sys_ack_n: 1'b1,
        loc_ack_n: 1'b1,
        default:   '0
    };

    mbad_state_t st;              // Registered state
    mbad_state_t nx;              // Next state
    logic [7:0]  filt_nx;         // Filtered pin levels, next value
    logic [1:0]  page_hit;        // Page match per bank
    logic [1:0]  block_hit;       // Page and block match per bank
    logic [7:0]  cs_en [2];       // Chip-select enables per bank
    logic [7:0]  irq_vec [2];     // Interrupt contribution per bank
    logic        sys_cmd;         // System bus read or write asserted
    logic        loc_cmd;         // Local bus read or write asserted
    logic        cmd_active;      // Command on the bus latched at start
    logic        astb_fall;       // Local address strobe just asserted
    logic [4:0]  cmd_cnt;         // Command delay in cycles
    logic [4:0]  ack_cnt;         // Access time before acknowledge
    logic        use_b;           // Bank B serves this access
    logic [7:0]  sel_cs;          // Enables of the serving bank
    logic        rom_half;        // Target half bank is read-only

    // Per-pin agreement filter and per-bank decode plus interrupt routing
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            // A change counts only once stages two and three agree
            assign filt_nx[gi] = (st.sync2[gi] == st.sync3[gi]) ? st.sync2[gi] : st.filt[gi];
        end
        for (gi = 0; gi < 2; gi++) begin : g_bank
            logic has_ee; // Either half of this bank holds electrically erasable ROM
            mbad_bank_decode u_dec (
                .addr_in       (st.addr),
                .cfg_in        (bank_cfg_in[gi]),
                .wide_in       (st.wide),
                .hbe_in        (st.hbe),
                .page_hit_out  (page_hit[gi]),
                .block_hit_out (block_hit[gi]),
                .cs_en_out     (cs_en[gi])
            );
            assign has_ee = (dev_type_in[2*gi] == DEV_EE_ROM)
                            || (dev_type_in[2*gi+1] == DEV_EE_ROM);
            // Ready and not-ready each go to their chosen level
            always_comb begin
                irq_vec[gi] = 8'h00;
                if (ee_route_en_in[gi] && has_ee) begin
                    irq_vec[gi][rdy_level_in]  = st.filt[`MBAD_SY_EE_RDY + gi];
                    irq_vec[gi][nrdy_level_in] = irq_vec[gi][nrdy_level_in]
                                                 | ~st.filt[`MBAD_SY_EE_RDY + gi];
                end
            end
        end
    endgenerate

    // Command decode and delay selection
    always_comb begin
        sys_cmd    = ~st.filt[`MBAD_SY_SYS_RD] | ~st.filt[`MBAD_SY_SYS_WR];
        loc_cmd    = ~st.filt[`MBAD_SY_LOC_RD] | ~st.filt[`MBAD_SY_LOC_WR];
        cmd_active = st.sysmode ? sys_cmd : loc_cmd;
        astb_fall  = st.filt[`MBAD_SY_LOC_ASTB] & ~filt_nx[`MBAD_SY_LOC_ASTB];
        case (cmd_delay_sel_in)
            2'h0:    cmd_cnt = 5'(`MBAD_CMD_DLY40_CYC);
            2'h1:    cmd_cnt = 5'(`MBAD_CMD_DLY60_CYC);
            default: cmd_cnt = 5'(`MBAD_CMD_DLY80_CYC);
        endcase
        // Counter steps of 100 ns, one to eight steps
        ack_cnt = 5'(({2'b00, ack_delay_sel_in} + 5'h01) * 5'(`MBAD_ACK_STEP_CYC));
        // Bank A wins when both banks claim the same address
        use_b    = ~block_hit[0];
        sel_cs   = use_b ? cs_en[1] : cs_en[0];
        rom_half = dev_type_in[{use_b, ~|sel_cs[3:0]}] == DEV_UV_ROM;
    end

    // Next-state logic
    always_comb begin
        nx       = st;
        nx.sync1 = {ee_ready_in, mode_sys_bus_in, loc_bus_in.wr_n, loc_bus_in.rd_n,
                    loc_astb_n_in, sys_bus_in.wr_n, sys_bus_in.rd_n};
        nx.sync2 = st.sync1;
        nx.sync3 = st.sync2;
        nx.filt  = filt_nx;
        nx.irq   = irq_vec[0] | irq_vec[1];
        case (st.fsm)
            S_IDLE: begin
                nx.sysmode = st.filt[`MBAD_SY_MODE];
                // Local bus: address is caught on its strobe, ahead of the command
                if (!st.filt[`MBAD_SY_MODE] && astb_fall) begin
                    nx.addr = loc_bus_in.addr;
                end
                if (st.filt[`MBAD_SY_MODE] ? sys_cmd : loc_cmd) begin
                    if (st.filt[`MBAD_SY_MODE]) begin
                        nx.addr  = sys_bus_in.addr;
                        nx.wdata = sys_bus_in.data;
                        nx.hbe   = ~sys_bus_in.high_byte_enable_n;
                        nx.wr    = ~st.filt[`MBAD_SY_SYS_WR];
                    end else begin
                        nx.wdata = loc_bus_in.data;
                        nx.hbe   = ~loc_bus_in.high_byte_enable_n;
                        nx.wr    = ~st.filt[`MBAD_SY_LOC_WR];
                    end
                    nx.wide = wide_mode_in;
                    nx.cnt  = cmd_cnt;
                    nx.fsm  = S_DELAY;
                end
            end
            S_DELAY: begin
                // Decode settles on the latched address while the delay runs
                if (st.cnt <= 5'h01) begin
                    nx.page_hit = page_hit;
                    if (|block_hit) begin
                        nx.mem_cs_n = use_b ? {~sel_cs, 8'hFF} : {8'hFF, ~sel_cs};
                        nx.mem_addr = st.wide ? st.addr[16:1] : st.addr[15:0];
                        nx.odd      = |(sel_cs & 8'hAA);
                        nx.mem_oe_n = st.wr;
                        // Read-only halves take the cycle but never see a write pulse
                        nx.mem_we_n = ~st.wr | rom_half;
                        nx.mem_wdata = (!st.wide || st.addr[0])
                                       ? {st.wdata[7:0], st.wdata[7:0]} : st.wdata;
                        nx.cnt      = ack_cnt;
                        nx.fsm      = S_ACCESS;
                    end else begin
                        nx.fsm = S_MISS;
                    end
                end else begin
                    nx.cnt = st.cnt - 5'h01;
                end
            end
            S_ACCESS: begin
                if (st.cnt <= 5'h01) begin
                    // Swap lanes so a single byte always lands where the host expects
                    if (!st.wide) begin
                        nx.rdata = {8'h00, st.odd ? mem_rdata_in[15:8] : mem_rdata_in[7:0]};
                    end else if (st.addr[0]) begin
                        nx.rdata = {mem_rdata_in[15:8], mem_rdata_in[15:8]};
                    end else begin
                        nx.rdata = mem_rdata_in;
                    end
                    nx.sys_oe    = st.sysmode & ~st.wr;
                    nx.loc_oe    = ~st.sysmode & ~st.wr;
                    nx.sys_ack_n = ~st.sysmode;
                    nx.loc_ack_n = st.sysmode;
                    // Write pulse ends on the same edge that the acknowledge goes out
                    nx.mem_we_n  = 1'b1;
                    nx.mem_oe_n  = 1'b1;
                    nx.mem_cs_n  = 16'hFFFF;
                    nx.fsm       = S_ACK;
                end else begin
                    nx.cnt = st.cnt - 5'h01;
                end
            end
            S_ACK: begin
                // Host keeps the command until it sees the acknowledge
                if (!cmd_active) begin
                    nx.sys_ack_n = 1'b1;
                    nx.loc_ack_n = 1'b1;
                    nx.sys_oe    = 1'b0;
                    nx.loc_oe    = 1'b0;
                    nx.fsm       = S_IDLE;
                end
            end
            S_MISS: begin
                // Another slave owns this address; stay silent until it ends
                if (!cmd_active) begin
                    nx.fsm = S_IDLE;
                end
            end
            default: begin
                nx.fsm = S_IDLE;
            end
        endcase
        if (rst_in) begin
            nx = ST_RST;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        st <= nx;
    end

    // Outputs straight from the state register
    assign sys_data_out    = st.rdata;
    assign sys_data_oe_out = st.sys_oe;
    assign sys_ack_n_out   = st.sys_ack_n;
    assign loc_data_out    = st.rdata;
    assign loc_data_oe_out = st.loc_oe;
    assign loc_ack_n_out   = st.loc_ack_n;
    assign mem_addr_out    = st.mem_addr;
    assign mem_cs_n_out    = st.mem_cs_n;
    assign mem_oe_n_out    = st.mem_oe_n;
    assign mem_we_n_out    = st.mem_we_n;
    assign mem_wdata_out   = st.mem_wdata;
    assign page_hit_out    = st.page_hit;
    assign int_req_out     = st.irq;

    // Accesses only happen inside a page that one bank claims
    a_page_match: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st.fsm == S_ACCESS) |-> ((st.addr[23:18] == bank_cfg_in[0].page)
                                 || (st.addr[23:18] == bank_cfg_in[1].page)))
        else $error("access outside both pages");

    // Chip selects only fall after the decode delay
    a_delay_first: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ((st.mem_cs_n != 16'hFFFF) && ($past(st.mem_cs_n) == 16'hFFFF))
        |-> ($past(st.fsm) == S_DELAY))
        else $error("chip select without decode delay");

    // Shortest delay choice leaves the delay state after one cycle
    a_cmd_delay40: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ((st.fsm == S_IDLE) ##1 ((st.fsm == S_DELAY) && ($past(cmd_delay_sel_in) == 2'h0)))
        |-> ##1 (st.fsm != S_DELAY))
        else $error("40 ns delay not one cycle");

    // The 60 ns choice holds the delay for two cycles
    a_cmd_delay60: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ((st.fsm == S_IDLE) ##1 ((st.fsm == S_DELAY) && ($past(cmd_delay_sel_in) == 2'h1)))
        |-> ##1 (st.fsm == S_DELAY) ##1 (st.fsm != S_DELAY))
        else $error("60 ns delay not two cycles");

    // Memory address follows the transfer mode's bit routing
    a_addr_route: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st.fsm == S_ACCESS)
        |-> (st.mem_addr == (st.wide ? st.addr[16:1] : st.addr[15:0])))
        else $error("device address routing wrong");

    // Write strobe only during a write access
    a_write_dir: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !st.mem_we_n |-> (st.wr && (st.fsm == S_ACCESS) && st.mem_oe_n))
        else $error("write strobe outside write access");

    // Data driven only on reads, after the access, on the active bus
    a_read_drive: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st.sys_oe || st.loc_oe)
        |-> (!st.wr && (st.fsm == S_ACK) && (st.sys_oe == st.sysmode) && !(st.sys_oe && st.loc_oe)))
        else $error("data driven wrongly");

    // Only the selected bus ever sees an acknowledge
    a_ack_one_bus: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!st.sys_ack_n |-> st.sysmode) and (!st.loc_ack_n |-> !st.sysmode))
        else $error("acknowledge on inactive bus");

    // A miss stays silent
    a_miss_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (st.fsm == S_MISS) |-> (st.sys_ack_n && st.loc_ack_n && !st.sys_oe && !st.loc_oe
                                && (st.mem_cs_n == 16'hFFFF)))
        else $error("miss drove the bus");

    // Acknowledge follows the shortest access-time count exactly
    a_ack_time: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ((st.fsm == S_DELAY) ##1 ((st.fsm == S_ACCESS) && ($past(ack_delay_sel_in) == 3'h0)))
        |-> ##1 (st.fsm == S_ACCESS) ##1 ((st.fsm == S_ACK) && !(st.sys_ack_n && st.loc_ack_n)))
        else $error("acknowledge delay wrong");

endmodule
`default_nettype wire

// [pkg/mbad_regs.svh]
`ifndef MBAD_REGS_SVH
`define MBAD_REGS_SVH

// System clock period
`define MBAD_CLK_NS           50

// Command-to-access delay choices (the shortest 20 ns choice is not offered)
`define MBAD_CMD_DLY40_NS     40
`define MBAD_CMD_DLY60_NS     60
`define MBAD_CMD_DLY80_NS     80
`define MBAD_CMD_DLY40_CYC    ((`MBAD_CMD_DLY40_NS + `MBAD_CLK_NS - 1) / `MBAD_CLK_NS)
`define MBAD_CMD_DLY60_CYC    ((`MBAD_CMD_DLY60_NS + `MBAD_CLK_NS - 1) / `MBAD_CLK_NS)
`define MBAD_CMD_DLY80_CYC    ((`MBAD_CMD_DLY80_NS + `MBAD_CLK_NS - 1) / `MBAD_CLK_NS)

// Acknowledge delay step of the access-time counter
`define MBAD_ACK_STEP_NS      100
`define MBAD_ACK_STEP_CYC     ((`MBAD_ACK_STEP_NS + `MBAD_CLK_NS - 1) / `MBAD_CLK_NS)

// Page field: six top address bits pick one of 64 pages of 256K bytes
`define MBAD_PAGE_MSB         23
`define MBAD_PAGE_LSB         18
`define MBAD_PAGE_OFS_MSB     17

// Size select codes 2K, 4K, 8K, 16K, 32K; shift of the smallest device
`define MBAD_SIZE_SHIFT_BASE  5'h0B
`define MBAD_SIZE_CODE_MAX    4'h4

// Offset select (one-hot) and the offset in device units
`define MBAD_OFF_SEL_0        4'h1
`define MBAD_OFF_SEL_2        4'h2
`define MBAD_OFF_SEL_4        4'h4
`define MBAD_OFF_SEL_8        4'h8
`define MBAD_OFF_UNITS_0      5'h00
`define MBAD_OFF_UNITS_2      5'h02
`define MBAD_OFF_UNITS_4      5'h04
`define MBAD_OFF_UNITS_8      5'h08

// Decode units per bank in each transfer mode (a wide unit is a pair of sites)
`define MBAD_SPAN_NARROW      18'h00008
`define MBAD_SPAN_WIDE        18'h00004

// Synchroniser bit positions and their reset value (strobes idle high)
`define MBAD_SY_SYS_RD        0
`define MBAD_SY_SYS_WR        1
`define MBAD_SY_LOC_ASTB      2
`define MBAD_SY_LOC_RD        3
`define MBAD_SY_LOC_WR        4
`define MBAD_SY_MODE          5
`define MBAD_SY_EE_RDY        6
`define MBAD_SYNC_RST         8'h1F

`endif

// [pkg/mbad_pkg.sv]
package mbad_pkg;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_DELAY,
        S_ACCESS,
        S_ACK,
        S_MISS
    } mbad_fsm_t;

    // Device type of one half bank
    typedef enum logic [2:0] {
        DEV_UV_ROM,
        DEV_EE_ROM,
        DEV_SRAM,
        DEV_INT_RAM,
        DEV_NV_RAM
    } mbad_dev_t;

    // Per-bank placement settings
    typedef struct packed {
        logic [5:0] page;
        logic [3:0] size_sel;
        logic [3:0] offset_sel;
    } mbad_bank_cfg_t;

    // One host bus as seen at the board pins (strobes active low)
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
        logic        rd_n;
        logic        wr_n;
        logic        high_byte_enable_n;
    } mbad_bus_in_t;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic [7:0]  sync3;
        logic [7:0]  filt;
        mbad_fsm_t   fsm;
        logic [4:0]  cnt;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        hbe;
        logic        wr;
        logic        sysmode;
        logic        wide;
        logic        odd;
        logic [1:0]  page_hit;
        logic [15:0] mem_addr;
        logic [15:0] mem_cs_n;
        logic [15:0] mem_wdata;
        logic        mem_oe_n;
        logic        mem_we_n;
        logic [15:0] rdata;
        logic        sys_oe;
        logic        loc_oe;
        logic        sys_ack_n;
        logic        loc_ack_n;
        logic [7:0]  irq;
    } mbad_state_t;

endpackage

// [hdl/mbad_bank_decode.sv]
`timescale 1ns/1ns
`default_nettype none
`include "mbad_regs.svh"

// Page compare and chip-select decode for one bank; purely combinational
module mbad_bank_decode (
    input  wire logic [23:0]              addr_in,
    input  wire mbad_pkg::mbad_bank_cfg_t cfg_in,
    input  wire logic                     wide_in,
    input  wire logic                     hbe_in,
    output logic                          page_hit_out,
    output logic                          block_hit_out,
    output logic [7:0]                    cs_en_out
);
    import mbad_pkg::*;

    logic [4:0]  shift;      // Log2 of the bytes covered by one decode unit
    logic        size_ok;    // Size code is one of the supported sizes
    logic [4:0]  off_units;  // Offset in device units
    logic        off_ok;     // Exactly one offset choice made
    logic [17:0] unit;       // Decode unit index within the page
    logic [17:0] first;      // First unit of the block
    logic [17:0] span;       // Units in the block
    logic [2:0]  site;       // Lowest site addressed
    logic        in_range;   // Address inside page and block

    // Page match, block range and chip-select enables
    always_comb begin
        page_hit_out = &(~(addr_in[`MBAD_PAGE_MSB:`MBAD_PAGE_LSB] ^ cfg_in.page));
        size_ok = (cfg_in.size_sel <= `MBAD_SIZE_CODE_MAX);
        // Wide mode pairs two sites, so one unit covers twice the bytes
        shift = `MBAD_SIZE_SHIFT_BASE + {1'b0, cfg_in.size_sel} + {4'h0, wide_in};
        off_ok = 1'b1;
        case (cfg_in.offset_sel)
            `MBAD_OFF_SEL_0: off_units = `MBAD_OFF_UNITS_0;
            `MBAD_OFF_SEL_2: off_units = `MBAD_OFF_UNITS_2;
            `MBAD_OFF_SEL_4: off_units = `MBAD_OFF_UNITS_4;
            `MBAD_OFF_SEL_8: off_units = `MBAD_OFF_UNITS_8;
            default: begin
                // No or several offsets fitted: bank never answers
                off_units = `MBAD_OFF_UNITS_0;
                off_ok    = 1'b0;
            end
        endcase
        unit  = addr_in[`MBAD_PAGE_OFS_MSB:0] >> shift;
        first = {13'h0000, off_units >> wide_in};
        span  = wide_in ? `MBAD_SPAN_WIDE : `MBAD_SPAN_NARROW;
        in_range = page_hit_out && size_ok && off_ok
                   && (unit >= first) && ((unit - first) < span);
        site = wide_in ? {unit[1:0], 1'b0} : unit[2:0];
        cs_en_out = 8'h00;
        if (in_range) begin
            if (wide_in) begin
                // Low device by address bit zero, high device by byte enable
                cs_en_out[site]        = ~addr_in[0];
                cs_en_out[site | 3'h1] = hbe_in;
            end else begin
                cs_en_out[site] = 1'b1;
            end
        end
        block_hit_out = in_range && (|cs_en_out);
    end

endmodule
`default_nettype wire

// [verif/mbad_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Processor board on either host bus; one command at a time
module mbad_host_model (
    input  wire logic              clk_in,
    input  wire logic              sys_mode_in,
    input  wire logic              sys_ack_n_in,
    input  wire logic              loc_ack_n_in,
    output mbad_pkg::mbad_bus_in_t bus_out,
    output logic                   astb_n_out
);
    import mbad_pkg::*;
    initial begin
        bus_out = '{24'h0, 16'h0, 1'b1, 1'b1, 1'b1};
        astb_n_out = 1'b1;
    end
    // One transfer; lat is cycles to acknowledge, 0 when none came
    task automatic xfer(input logic [23:0] a, input logic [15:0] d, input logic wr,
                        input logic hbe, output int lat);
        lat = 0;
        // Strobe idles high for three edges so the pin filter sees each new fall
        repeat (3) @(posedge clk_in);
        #5 bus_out = '{a, d, 1'b1, 1'b1, ~hbe};
        astb_n_out = 1'b0;
        // Strobe settles through the pin filter before the command
        repeat (4) @(posedge clk_in);
        #5 bus_out = '{a, d, wr, ~wr, ~hbe};
        for (int i = 1; i <= 40 && lat == 0; i++) begin
            // Acknowledge is looked at once it has settled after the edge
            @(posedge clk_in) #5;
            if ((sys_mode_in ? sys_ack_n_in : loc_ack_n_in) === 1'b0) lat = i;
        end
        // Released lines show the inverse, so stale values never read as good
        bus_out = '{~a, ~d, 1'b1, 1'b1, hbe};
        astb_n_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// [verif/mbad_top_bench.sv]
`timescale 1ns/1ns
`default_nettype none
// Host transfers, bank placement and ready routing
module mbad_top_bench;
    import mbad_pkg::*;
    logic           clk_sys_in, rst_in, mode, wide, sys_oe, loc_oe, sys_ack_n, loc_ack_n;
    logic           oe_n, we_n, astb_n;
    logic [1:0]     cdly, ee_rdy, route_en, hit, dir_seen;
    logic [2:0]     adly, rdy_lvl, nrdy_lvl;
    logic [7:0]     irq;
    logic [15:0]    rdata, sys_d, loc_d, ma, cs_n, wd, cs_seen, ma_seen, wd_seen;
    mbad_bank_cfg_t [1:0] cfg;
    mbad_dev_t [3:0] dev;
    mbad_bus_in_t   host;
    int             err_count, checked, lat, lat0;
    mbad_top u_mbad_top (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_sys_bus_in(mode),
        .wide_mode_in(wide), .cmd_delay_sel_in(cdly), .ack_delay_sel_in(adly),
        .bank_cfg_in(cfg), .dev_type_in(dev), .sys_bus_in(host), .loc_bus_in(host),
        .loc_astb_n_in(astb_n), .mem_rdata_in(rdata), .ee_ready_in(ee_rdy),
        .ee_route_en_in(route_en), .rdy_level_in(rdy_lvl), .nrdy_level_in(nrdy_lvl),
        .sys_data_out(sys_d), .sys_data_oe_out(sys_oe), .sys_ack_n_out(sys_ack_n),
        .loc_data_out(loc_d), .loc_data_oe_out(loc_oe), .loc_ack_n_out(loc_ack_n),
        .mem_addr_out(ma), .mem_cs_n_out(cs_n), .mem_oe_n_out(oe_n), .mem_we_n_out(we_n),
        .mem_wdata_out(wd), .page_hit_out(hit), .int_req_out(irq));
    mbad_host_model u_mbad_host_model (.clk_in(clk_sys_in), .sys_mode_in(mode),
        .sys_ack_n_in(sys_ack_n), .loc_ack_n_in(loc_ack_n), .bus_out(host), .astb_n_out(astb_n));
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    // Memory side seen during each access
    always @(posedge clk_sys_in) begin
        if (cs_n !== 16'hFFFF) cs_seen <= cs_n;
        if (cs_n !== 16'hFFFF) {ma_seen, dir_seen} <= {ma, oe_n, we_n};
        if (we_n === 1'b0) wd_seen <= wd;
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) err_count++;
        if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Odd site of bank A, then longer access and command delays
    task automatic narrow_read();
        u_mbad_host_model.xfer(24'h540801, 16'h0, 1'b0, 1'b0, lat0);
        check("rd data", sys_d, 16'h00B4);
        check("rd dir", {sys_oe, dir_seen}, 3'b101);
        check("page hit", hit, 2'b11);
        check("rd cs", cs_seen, 16'hFFFD);
        check("rd addr", ma_seen[10:0], 11'h001);
        adly = 3'h3;
        u_mbad_host_model.xfer(24'h540801, 16'h0, 1'b0, 1'b0, lat);
        check("ack delay", lat - lat0, 6);
        adly = 3'h0;
        cdly = 2'h1;
        u_mbad_host_model.xfer(24'h540801, 16'h0, 1'b0, 1'b0, lat);
        check("cmd delay", lat - lat0, 1);
    endtask
    task automatic narrow_write();
        u_mbad_host_model.xfer(24'h540003, 16'h003C, 1'b1, 1'b0, lat);
        check("wr ack", lat != 0, 1);
        check("wr data", wd_seen, 16'h3C3C);
        check("wr cs", cs_seen, 16'hFFFE);
        check("wr dir", dir_seen, 2'b10);
        // Sites 4-7 of bank A hold UV ROM: acked, but no write pulse
        u_mbad_host_model.xfer(24'h542000, 16'h0055, 1'b1, 1'b0, lat);
        check("rom wr", {lat != 0, dir_seen, wd_seen}, 19'h73C3C);
    endtask
    // Bank B sits above bank A in the same page; end of block and other page miss
    task automatic bank_b_and_miss();
        u_mbad_host_model.xfer(24'h545800, 16'h0, 1'b0, 1'b0, lat);
        check("b cs", cs_seen, 16'hF7FF);
        u_mbad_host_model.xfer(24'h548000, 16'h0, 1'b0, 1'b0, lat);
        check("block miss", {lat != 0, sys_oe, hit}, 3);
        u_mbad_host_model.xfer(24'h581000, 16'h0, 1'b0, 1'b0, lat);
        check("page miss", {lat != 0, sys_oe, hit}, 0);
    endtask
    task automatic wide_local();
        mode = 1'b0;
        wide = 1'b1;
        repeat (6) @(posedge clk_sys_in);
        u_mbad_host_model.xfer(24'h540802, 16'h0, 1'b0, 1'b1, lat);
        check("wide data", loc_d, 16'hB4C7);
        check("wide cs", cs_seen, 16'hFFFC);
        check("wide addr", ma_seen[10:0], 11'h401);
        check("sys quiet", sys_ack_n, 1);
        check("loc oe", {loc_oe, sys_oe}, 2'b10);
        u_mbad_host_model.xfer(24'h540802, 16'h0, 1'b0, 1'b0, lat);
        check("low cs", cs_seen, 16'hFFFE);
    endtask
    task automatic ready_route();
        repeat (8) @(posedge clk_sys_in);
        #5 check("ready irq", irq, 8'h20);
        ee_rdy = 2'b00;
        repeat (8) @(posedge clk_sys_in);
        #5 check("busy irq", irq, 8'h04);
    endtask
    initial begin
        #2000000 err_count++;
        report_and_stop();
    end
    initial begin
        {err_count, checked, rst_in, mode, wide, cdly, adly} = {32'h0, 32'h0, 1'b1, 1'b1, 6'h00};
        {rdata, ee_rdy, route_en, rdy_lvl, nrdy_lvl} = {16'hB4C7, 2'b01, 2'b01, 3'h5, 3'h2};
        cfg = '{'{6'h15, 4'h0, 4'h8}, '{6'h15, 4'h0, 4'h1}};
        dev = '{DEV_SRAM, DEV_SRAM, DEV_UV_ROM, DEV_EE_ROM};
        repeat (6) @(posedge clk_sys_in);
        #5 rst_in = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        narrow_read();
        narrow_write();
        bank_b_and_miss();
        wide_local();
        ready_route();
        report_and_stop();
    end
endmodule
`default_nettype wire
